// ===== src/fspc_consts.svh
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
`define REG_AW 4
`define REG_CTRL_ADDR 4'h0
`define CTRL_W 5
`define RESV_W 3
`define CMD_FILL 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_FUSE 5'h09
`define CMD_CLEAR 5'h11
`define WORD_LSB 1
`define WORD_W 4
`define PAGE_LSB 5
`define PAGE_W 5
`define WORDS 5'h10
`define SPM_WIN 3'h4
`define LPM_LAST 3'h2
`define FUSE_LOW_ADDR 16'h0000
`define LOCK_ADDR 16'h0001
`define FUSE_HIGH_ADDR 16'h0003
`define BLANK_WORD 16'hFFFF
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
`define CLK_NS 5
`endif

// ===== src/fspc_pkg.sv
package fspc_pkg;
`include "fspc_consts.svh"
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_STREAM = 3'h2,
        ST_TIME = 3'h4
    } op_state_e;

    typedef struct packed {
        op_state_e state;
        logic [`CTRL_W-1:0] ctrl;
        logic [2:0] win;
        logic [31:0] timer;
        logic [4:0] cnt;
        logic [`WORDS-1:0] valid;
        logic erase;
        logic halt;
        logic [7:0] rdata;
        logic [7:0] lpm_data;
        logic lpm_fuse;
        logic lpm_rd;
        logic [15:0] lpm_addr;
        logic fl_erase;
        logic fl_write;
        logic [`PAGE_W-1:0] fl_page;
        logic fl_we;
        logic [`WORD_W-1:0] fl_word;
        logic [15:0] fl_wdata;
    } ctrl_state_s;

    typedef struct packed {
        logic [`WORDS-1:0][15:0] mem;
        logic [15:0] rdata;
    } mem_state_s;
endpackage : fspc_pkg

// ===== src/buf_if.sv
`timescale 1ns/1ps
interface buf_if;
    logic ce;
    logic we;
    logic [3:0] waddr;
    logic [3:0] raddr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl(output ce, we, waddr, raddr, wdata, input rdata);
    modport mem(input ce, we, waddr, raddr, wdata, output rdata);
endinterface : buf_if

// ===== src/page_buf_mem.sv
`timescale 1ns/1ps
module page_buf_mem
    import fspc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    buf_if.mem bus
);
    mem_state_s r;
    mem_state_s n;

    always_comb begin
        n = r;
        n.rdata = r.mem[bus.raddr];
        if (bus.we) begin
            n.mem[bus.waddr] = bus.wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else if (bus.ce) begin
            r <= n;
        end
    end

    assign bus.rdata = r.rdata;
endmodule : page_buf_mem

// ===== src/flash_self_program_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Page write: pointer, command, store within four.
// - Core halted for whole page write.
// - Low pointer bits word, high bits page.
// - Load reads by byte, bit zero picks byte.
// - EEPROM write blocks programming and fuse reads.
// - Lock byte read at address one, load within three.
// - Enable and fuse-read bits self-clear on timeout.
// - Address zero low fuse, three high fuse.
// - Running write finishes across system reset.
// - Erase and write timed, 3.7 to 4.5 ms.
// - Clear-buffer bit discards loaded buffer data.
// - Write command writes buffer to pointer page.
// - Erase command erases pointer page.
// - Enable alone stores register pair into buffer.
// - Enable clears after store or held during operation.
// - Unknown command patterns have no effect.
// - Pointer bit zero selects lock or low fuse; address three gives high fuse.
// - Page erase: command then store within four.
// - Buffer emptied after page write and reset.
// - Store ignored unless self-program fuse programmed.
module flash_self_program_ctrl
    import fspc_pkg::*;
#(
    parameter int PROG_CYCLES = (`PROG_MIN_NS + `CLK_NS - 1) / `CLK_NS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic sys_reset_req,
    input wire logic [`REG_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] r_pair,
    input wire logic spm_instr,
    input wire logic lpm_instr,
    input wire logic eeprom_write_busy,
    input wire logic self_prog_fuse_n,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [7:0] lock_bits,
    output logic cpu_halt,
    output logic lpm_fuse_valid,
    output logic [7:0] lpm_fuse_data,
    output logic flash_rd,
    output logic [14:0] flash_rd_word,
    output logic flash_rd_byte_hi,
    output logic flash_erase,
    output logic flash_write,
    output logic [`PAGE_W-1:0] flash_page,
    output logic flash_word_we,
    output logic [`WORD_W-1:0] flash_word,
    output logic [15:0] flash_wdata
);
    ctrl_state_s r;
    ctrl_state_s n;
    buf_if bus ();
    logic ctrl_wr;
    logic spm_ok;
    logic fuse_rd;
    logic [`WORD_W-1:0] zword;
    logic [`PAGE_W-1:0] zpage;

    // Lock byte sits at odd addresses except three (high fuse), low fuse at even ones.
    function automatic logic [7:0] fuse_sel(input logic [15:0] z,
        input logic [7:0] flo, input logic [7:0] fhi, input logic [7:0] lk);
        // The high fuse address is odd too, so it must win over the lock.
        if (z == `FUSE_HIGH_ADDR) begin
            fuse_sel = fhi;
        end else if (z[0]) begin
            fuse_sel = lk;
        end else begin
            fuse_sel = flo;
        end
    endfunction : fuse_sel

    assign zword = z_ptr[`WORD_LSB +: `WORD_W];
    assign zpage = z_ptr[`PAGE_LSB +: `PAGE_W];
    assign ctrl_wr = reg_wr && reg_addr == `REG_CTRL_ADDR;
    assign spm_ok = spm_instr && !self_prog_fuse_n && r.win != 3'h0 &&
        !eeprom_write_busy && r.state == ST_IDLE;
    assign fuse_rd = r.ctrl == `CMD_FUSE && r.win >= `LPM_LAST &&
        !eeprom_write_busy;

    page_buf_mem u_buf (
        .clk(clk),
        .resetn(resetn),
        .bus(bus.mem)
    );

    always_comb begin
        n = r;
        n.lpm_rd = 1'b0;
        n.lpm_fuse = 1'b0;
        n.fl_we = 1'b0;
        bus.ce = clk_en;
        bus.we = 1'b0;
        bus.waddr = zword;
        bus.wdata = r_pair;
        bus.raddr = r.cnt[`WORD_W-1:0];
        if (reg_rd) begin
            n.rdata = (reg_addr == `REG_CTRL_ADDR) ?
                {`RESV_W'h0, r.ctrl} : 8'h00;
        end
        unique case (r.state)
            ST_IDLE: begin
                if (r.win != 3'h0) begin
                    n.win = r.win - 3'h1;
                    if (r.win == 3'h1) begin
                        n.ctrl = '0;
                    end
                end
                if (r.ctrl == `CMD_FUSE && r.win == `LPM_LAST &&
                    !lpm_instr) begin
                    n.ctrl = '0;
                    n.win = 3'h0;
                end
                if (lpm_instr) begin
                    n.lpm_addr = z_ptr;
                    if (fuse_rd) begin
                        n.lpm_fuse = 1'b1;
                        n.lpm_data = fuse_sel(z_ptr, fuse_low_byte,
                            fuse_high_byte, lock_bits);
                        n.ctrl = '0;
                        n.win = 3'h0;
                    end else begin
                        n.lpm_rd = 1'b1;
                    end
                end
                if (spm_ok) begin
                    n.win = 3'h0;
                    n.ctrl = '0;
                    unique case (r.ctrl)
                        `CMD_FILL: begin
                            // The buffer cell is write-once until cleared.
                            if (!r.valid[zword]) begin
                                bus.we = 1'b1;
                                n.valid[zword] = 1'b1;
                            end
                        end
                        `CMD_ERASE, `CMD_WRITE: begin
                            n.ctrl = r.ctrl;
                            n.halt = 1'b1;
                            n.fl_page = zpage;
                            n.erase = r.ctrl == `CMD_ERASE;
                            n.fl_erase = r.ctrl == `CMD_ERASE;
                            n.fl_write = r.ctrl == `CMD_WRITE;
                            n.cnt = 5'h0;
                            n.timer = 32'(PROG_CYCLES - 1);
                            n.state = (r.ctrl == `CMD_WRITE) ?
                                ST_STREAM : ST_TIME;
                        end
                        default: begin
                        end
                    endcase
                end
                if (ctrl_wr && !eeprom_write_busy) begin
                    unique case (reg_wdata[`CTRL_W-1:0])
                        `CMD_CLEAR: begin
                            n.valid = '0;
                            n.ctrl = '0;
                            n.win = 3'h0;
                        end
                        `CMD_FILL, `CMD_ERASE, `CMD_WRITE, `CMD_FUSE: begin
                            n.ctrl = reg_wdata[`CTRL_W-1:0];
                            n.win = `SPM_WIN;
                        end
                        default: begin
                        end
                    endcase
                end
                // Loaded words are lost if the EEPROM is written meanwhile.
                if (eeprom_write_busy) begin
                    n.valid = '0;
                end
            end
            ST_STREAM: begin
                // Read data lag the read address by one cycle.
                if (r.cnt != 5'h0) begin
                    n.fl_we = 1'b1;
                    n.fl_word = 4'(r.cnt - 5'h1);
                    n.fl_wdata = r.valid[4'(r.cnt - 5'h1)] ?
                        bus.rdata : `BLANK_WORD;
                end
                n.cnt = r.cnt + 5'h1;
                if (r.cnt == `WORDS) begin
                    n.state = ST_TIME;
                end
            end
            ST_TIME: begin
                if (r.timer == 32'h0) begin
                    n.state = ST_IDLE;
                    n.halt = 1'b0;
                    n.ctrl = '0;
                    n.fl_erase = 1'b0;
                    n.fl_write = 1'b0;
                    if (!r.erase) begin
                        n.valid = '0;
                    end
                end else begin
                    n.timer = r.timer - 32'h1;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        // A system reset spares the running operation so it can finish.
        if (sys_reset_req && r.state == ST_IDLE) begin
            n.valid = '0;
            n.ctrl = '0;
            n.win = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{state: ST_IDLE, default: '0};
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign cpu_halt = r.halt;
    assign lpm_fuse_valid = r.lpm_fuse;
    assign lpm_fuse_data = r.lpm_data;
    assign flash_rd = r.lpm_rd;
    assign flash_rd_word = r.lpm_addr[15:1];
    assign flash_rd_byte_hi = r.lpm_addr[0];
    assign flash_erase = r.fl_erase;
    assign flash_write = r.fl_write;
    assign flash_page = r.fl_page;
    assign flash_word_we = r.fl_we;
    assign flash_word = r.fl_word;
    assign flash_wdata = r.fl_wdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_write_start;
        clk_en && spm_ok && r.ctrl == `CMD_WRITE |=>
            r.state == ST_STREAM && r.halt && r.fl_page == $past(zpage);
    endproperty
    a_write_start: assert property (p_write_start)
        else $error("page write did not start");

    property p_halt;
        r.state != ST_IDLE |-> cpu_halt && r.ctrl[0];
    endproperty
    a_halt: assert property (p_halt)
        else $error("core not halted during operation");

    property p_ee_block;
        clk_en && ctrl_wr && eeprom_write_busy |=> r.win != `SPM_WIN;
    endproperty
    a_ee_block: assert property (p_ee_block)
        else $error("command accepted during EEPROM write");

    property p_timeout;
        clk_en && r.state == ST_IDLE && r.win == 3'h1 && !ctrl_wr &&
            !spm_instr |=>
            r.ctrl == '0;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("command bits did not expire");

    property p_fuse_data;
        clk_en && lpm_instr && fuse_rd && r.state == ST_IDLE |=>
            lpm_fuse_valid && lpm_fuse_data == fuse_sel($past(z_ptr),
            $past(fuse_low_byte), $past(fuse_high_byte), $past(lock_bits));
    endproperty
    a_fuse_data: assert property (p_fuse_data)
        else $error("wrong fuse or lock byte returned");

    property p_resv;
        clk_en && reg_rd |=> reg_rdata[7:`CTRL_W] == `RESV_W'h0;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved bits read nonzero");

    property p_timer;
        $rose(r.state == ST_TIME) |-> r.timer == 32'(PROG_CYCLES - 1);
    endproperty
    a_timer: assert property (p_timer)
        else $error("programming time not loaded");

    property p_fuse_off;
        clk_en && spm_instr && self_prog_fuse_n && r.state == ST_IDLE |=>
            r.state == ST_IDLE && !cpu_halt;
    endproperty
    a_fuse_off: assert property (p_fuse_off)
        else $error("store ran with fuse unprogrammed");

    property p_clear_after;
        clk_en && r.state == ST_TIME && r.timer == 32'h0 && !r.erase |=>
            r.valid == '0 && !cpu_halt;
    endproperty
    a_clear_after: assert property (p_clear_after)
        else $error("buffer not emptied after page write");

    property p_busy_lock;
        r.state == ST_STREAM |=> $stable(r.ctrl) && r.win == 3'h0;
    endproperty
    a_busy_lock: assert property (p_busy_lock)
        else $error("command changed during operation");

    property p_clear_page_buffer;
        clk_en && ctrl_wr && !eeprom_write_busy && r.state == ST_IDLE &&
            reg_wdata[`CTRL_W-1:0] == `CMD_CLEAR |=> r.valid == '0;
    endproperty
    a_clear_page_buffer: assert property (p_clear_page_buffer)
        else $error("buffer not cleared");
endmodule : flash_self_program_ctrl

// ===== test/core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    output logic spm_instr,
    output logic lpm_instr,
    output logic [15:0] z_ptr,
    output logic [15:0] r_pair
);
    initial begin
        spm_instr = 1'b0;
        lpm_instr = 1'b0;
        z_ptr = 16'h0000;
        r_pair = 16'h0000;
    end

    // One instruction lasts one cycle; the data pair is scrambled after it
    // so that a late sample of a stale word cannot pass by accident.
    task automatic issue(input logic st, input logic [15:0] z,
            input logic [15:0] d);
        z_ptr <= z;
        r_pair <= d;
        spm_instr <= st;
        lpm_instr <= ~st;
        @(posedge clk);
        spm_instr <= 1'b0;
        lpm_instr <= 1'b0;
        r_pair <= ~d;
    endtask : issue
endmodule : core_model

// ===== test/test_flash_self_program_ctrl.sv
`timescale 1ns/1ps
module test_flash_self_program_ctrl;
    import fspc_pkg::*;
    localparam int PC = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sys_reset_req = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic eeprom_write_busy = 1'b0;
    logic self_prog_fuse_n = 1'b0;
    logic [7:0] flo = 8'h5A;
    logic [7:0] fhi = 8'hC3;
    logic [7:0] lk = 8'hFC;
    logic [7:0] reg_rdata, lpm_fuse_data, rd;
    logic cpu_halt, lpm_fuse_valid, flash_rd, flash_rd_byte_hi;
    logic flash_erase, flash_write, flash_word_we, spm_instr, lpm_instr;
    logic [14:0] flash_rd_word;
    logic [4:0] flash_page;
    logic [3:0] flash_word;
    logic [15:0] flash_wdata, z_ptr, r_pair;
    logic [15:0] fill [16];
    logic [15:0] got [16];
    logic [15:0] zs [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0002, 16'h0005};
    int halt_cycles = 0;
    int seed = 5;
    int err_count = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;

    flash_self_program_ctrl #(.PROG_CYCLES(PC)) i_dut (.clk(clk),
        .resetn(resetn), .clk_en(1'b1), .sys_reset_req(sys_reset_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .z_ptr(z_ptr),
        .r_pair(r_pair), .spm_instr(spm_instr), .lpm_instr(lpm_instr),
        .eeprom_write_busy(eeprom_write_busy),
        .self_prog_fuse_n(self_prog_fuse_n), .fuse_low_byte(flo),
        .fuse_high_byte(fhi), .lock_bits(lk), .cpu_halt(cpu_halt),
        .lpm_fuse_valid(lpm_fuse_valid), .lpm_fuse_data(lpm_fuse_data),
        .flash_rd(flash_rd), .flash_rd_word(flash_rd_word),
        .flash_rd_byte_hi(flash_rd_byte_hi), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page),
        .flash_word_we(flash_word_we), .flash_word(flash_word),
        .flash_wdata(flash_wdata));

    core_model i_core (.clk(clk), .spm_instr(spm_instr),
        .lpm_instr(lpm_instr), .z_ptr(z_ptr), .r_pair(r_pair));

    always @(posedge clk) begin
        if (cpu_halt === 1'b1) halt_cycles <= halt_cycles + 1;
        if (flash_word_we === 1'b1) got[flash_word] <= flash_wdata;
    end

    function automatic logic [7:0] exp_fuse(input logic [15:0] z);
        if (z == 16'h0003) return fhi;
        if (z[0]) return lk;
        return flo;
    endfunction : exp_fuse

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] d);
        @(posedge clk);
        reg_addr <= 4'h0;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic wait_idle;
        int n;
        n = 0;
        while (cpu_halt === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 2000) err_count++;
    endtask : wait_idle

    task automatic fill_word(input logic [3:0] w, input logic [15:0] d);
        reg_write(8'h01);
        i_core.issue(1'b1, {11'h000, w, 1'b1}, d);
        // A buffer word takes only its first value until it is cleared.
        if (fill[w] === 16'hFFFF) fill[w] = d;
    endtask : fill_word

    // Streams the buffer to a page; a system reset may land mid-operation.
    task automatic page_write(input logic [4:0] pg, input bit rst);
        halt_cycles = 0;
        foreach (got[i]) got[i] = 16'h0000;
        reg_write(8'h05);
        i_core.issue(1'b1, {6'h00, pg, 5'h00}, 16'h1234);
        #1;
        check(cpu_halt, 16'h0001);
        check(flash_write, 16'h0001);
        check(flash_page, pg);
        reg_write(8'h03);
        reg_read(4'h0, rd);
        check(rd, 8'h05);
        if (rst) begin
            sys_reset_req <= 1'b1;
            @(posedge clk);
            sys_reset_req <= 1'b0;
            #1;
            check(cpu_halt, 16'h0001);
        end
        wait_idle;
        for (int i = 0; i < 16; i++) check(got[i], fill[i]);
        check(halt_cycles >= 16 + PC, 16'h0001);
        foreach (fill[i]) fill[i] = 16'hFFFF;
    endtask : page_write

    task automatic fuse_read(input logic [15:0] z, input int gap);
        reg_write(8'h09);
        repeat (gap) @(posedge clk);
        i_core.issue(1'b0, z, 16'h0000);
        #1;
        if (gap < 3 && !eeprom_write_busy) begin
            check(lpm_fuse_valid, 16'h0001);
            check(lpm_fuse_data, exp_fuse(z));
        end else begin
            check(lpm_fuse_valid, 16'h0000);
            check(flash_rd, 16'h0001);
            check(flash_rd_word, z[15:1]);
            check(flash_rd_byte_hi, z[0]);
        end
    endtask : fuse_read

    task automatic blocked_store;
        reg_write(8'h05);
        i_core.issue(1'b1, 16'h0020, 16'h0000);
        #1;
        check(cpu_halt, 16'h0000);
    endtask : blocked_store

    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        #100000;
        err_count++;
        results;
    end

    initial begin
        foreach (fill[i]) fill[i] = 16'hFFFF;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        reg_read(4'h0, rd);
        check(rd, 8'h00);
        reg_read(4'h9, rd);
        check(rd, 8'h00);
        reg_write(8'hE5);
        reg_read(4'h0, rd);
        check(rd, 8'h05);
        repeat (4) @(posedge clk);
        reg_read(4'h0, rd);
        check(rd, 8'h00);
        for (int k = 0; k < 8; k++) begin
            rd = 8'($random(seed));
            if (!(rd[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11})) begin
                reg_write(rd);
                reg_read(4'h0, rd);
                check(rd, 8'h00);
            end
        end
        for (int k = 0; k < 3; k++) begin
            fill_word(4'($random(seed)), 16'($random(seed)));
        end
        page_write(5'h0B, 1'b0);
        page_write(5'h0B, 1'b1);
        fill_word(4'h7, 16'hA55A);
        reg_write(8'h11);
        foreach (fill[i]) fill[i] = 16'hFFFF;
        page_write(5'h1F, 1'b0);
        halt_cycles = 0;
        reg_write(8'h03);
        i_core.issue(1'b1, 16'h0160, 16'h0000);
        #1;
        check(flash_erase, 16'h0001);
        check(flash_page, 16'h000B);
        wait_idle;
        check(halt_cycles >= PC, 16'h0001);
        reg_read(4'h0, rd);
        check(rd, 8'h00);
        foreach (zs[i]) for (int g = 0; g < 4; g++) fuse_read(zs[i], g);
        eeprom_write_busy <= 1'b1;
        fuse_read(16'h0001, 0);
        blocked_store;
        eeprom_write_busy <= 1'b0;
        self_prog_fuse_n <= 1'b1;
        blocked_store;
        self_prog_fuse_n <= 1'b0;
        results;
    end
endmodule : test_flash_self_program_ctrl
